// *** logic/sebf_pkg.sv ***
// Shared constants and carrier types for the serial EEPROM bus front end
package sebf_pkg;
  localparam int CLK_MHZ = 100;
  localparam int TWC_MS = 5;
  localparam int TWC_CYCLES = TWC_MS * CLK_MHZ * 1000;
  localparam int FILT_LEN = 3;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_BITS = 5;
  localparam int BITS_PER_BYTE = 8;
  localparam logic [3:0] DEV_CODE_DFLT = 4'h5; // Arbitrary value
  localparam logic [1:0] IDX_CTRL = 2'h0;
  localparam logic [1:0] IDX_ADDR_HI = 2'h1;
  localparam logic [1:0] IDX_ADDR_LO = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_RX_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_TX_ACK = 5'h10
  } sebf_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sebf_wr_s;
endpackage

// *** logic/sebf_front_end.sv ***
// Two-wire bus slave front end with page buffer FIFO
// What this block does
// - Respond only when all three chip address pins match the chip-select bits.
// - Write-protect high inhibits array writes; reads are never affected.
// - SDA falling while SCL high is a Start; next byte is a control byte.
// - SDA rising while SCL high is a Stop; operations end with one.
// - One SCL pulse per bit; master decides byte count.
// - Overlong writes keep only the newest 32 bytes, dropping oldest first.
// - Receiver acknowledges each addressed byte on a ninth clock pulse.
// - Acknowledger holds SDA low through the whole ack clock high phase.
// - No acknowledge at all while a programming cycle runs.
// - Master nacks the last read byte; device then releases SDA.
// - First byte after Start: device-type code then chip-select bits A2 A1 A0.
// - Chip-select bits must equal the chip address pin levels.
// - Control byte LSB one selects read, zero selects write.
// - Two word-address bytes follow a write, high first; upper three bits ignored.
// - On full match, acknowledge and enter read or write handling.
// - Stop after write data launches the write cycle; device stays unresponsive meanwhile.
// - Write cycle completes within 5 ms.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module sebf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, count;
  // Depth must be a power of two for the wrapping pointers
  assign count = wr_ptr - rd_ptr;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sebf_front_end #(
  parameter logic [3:0] DEV_CODE = sebf_pkg::DEV_CODE_DFLT, // Arbitrary value
  parameter int TWC_CYCLES = sebf_pkg::TWC_CYCLES,
  parameter int BUF_DEPTH = sebf_pkg::PAGE_BYTES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  input wire logic wp_pin,
  input wire logic chip_select_pin_bit0,
  input wire logic chip_select_pin_bit1,
  input wire logic chip_select_pin_bit2,
  output logic rd_req,
  output logic [sebf_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [sebf_pkg::DATA_W-1:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output sebf_pkg::sebf_wr_s wr_word,
  output logic busy
);
  function automatic logic [sebf_pkg::ADDR_W-1:0] page_inc(input logic [sebf_pkg::ADDR_W-1:0] a);
    page_inc = {a[sebf_pkg::ADDR_W-1:sebf_pkg::PAGE_BITS],
                a[sebf_pkg::PAGE_BITS-1:0] + 1'b1};
  endfunction
  function automatic logic filt(input logic [sebf_pkg::FILT_LEN-1:0] h, input logic cur);
    filt = (&h) ? 1'b1 : ((|h) ? cur : 1'b0);
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and glitch filters
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [sebf_pkg::FILT_LEN-1:0] scl_h;
  logic [sebf_pkg::FILT_LEN-1:0] sda_h;
  logic scl_f, sda_f, scl_p, sda_p;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1 <= 6'h3F;
      pin_s2 <= 6'h3F;
    end else begin
      pin_s1 <= {scl_pin, sda_pin_in, wp_pin, chip_select_pin_bit2,
                 chip_select_pin_bit1, chip_select_pin_bit0};
      pin_s2 <= pin_s1;
    end
  end

  // Filter needs the history to agree, so spikes shorter than it vanish
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_h <= '1;
      sda_h <= '1;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_h <= {scl_h[sebf_pkg::FILT_LEN-2:0], pin_s2[5]};
      sda_h <= {sda_h[sebf_pkg::FILT_LEN-2:0], pin_s2[4]};
      scl_f <= filt(scl_h, scl_f);
      sda_f <= filt(sda_h, sda_f);
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_f && !scl_p;
  assign scl_fall = !scl_f && scl_p;
  assign start_det = scl_f && scl_p && sda_p && !sda_f;
  assign stop_det = scl_f && scl_p && !sda_p && sda_f;

  //////////////////////////////////////////////////////////////////////////////
  // Bus state machine
  sebf_pkg::sebf_state_e state;
  logic [sebf_pkg::DATA_W-1:0] rx_sr;
  logic [sebf_pkg::DATA_W-1:0] tx_sr;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic is_read, got_ack, rd_pend, data_seen;
  logic [sebf_pkg::ADDR_W-1:0] addr_ptr;
  logic [sebf_pkg::DATA_W-1:0] push_data;
  logic push_pend, byte_end, ctrl_match, fifo_in_ready;

  assign byte_end = (state == sebf_pkg::ST_RX) && scl_fall
                    && (bit_cnt == 4'(sebf_pkg::BITS_PER_BYTE));
  assign ctrl_match = (rx_sr[7:4] == DEV_CODE)
                      && (rx_sr[3:1] == pin_s2[2:0])
                      && !busy;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= sebf_pkg::ST_IDLE;
      rx_sr <= 8'h00;
      tx_sr <= 8'hFF;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      is_read <= 1'b0;
      got_ack <= 1'b0;
      rd_req <= 1'b0;
      rd_pend <= 1'b0;
      rd_addr <= 13'h0000;
      addr_ptr <= 13'h0000;
      sda_pin_oe <= 1'b0;
      sda_pin_out <= 1'b0;
      push_pend <= 1'b0;
      push_data <= 8'h00;
      data_seen <= 1'b0;
    end else begin
      rd_req <= 1'b0;
      rd_pend <= rd_req;
      if (rd_pend) begin
        tx_sr <= rd_data;
      end
      if (push_pend && fifo_in_ready) begin
        push_pend <= 1'b0;
      end
      if (start_det) begin
        // Abandon any byte in flight and await a fresh control byte
        state <= sebf_pkg::ST_RX;
        bit_cnt <= 4'h0;
        byte_idx <= sebf_pkg::IDX_CTRL;
        sda_pin_oe <= 1'b0;
        data_seen <= 1'b0;
      end else if (stop_det) begin
        state <= sebf_pkg::ST_IDLE;
        sda_pin_oe <= 1'b0;
        data_seen <= 1'b0;
      end else begin
        unique case (state)
          sebf_pkg::ST_IDLE: ;
          sebf_pkg::ST_RX: begin
            if (scl_rise) begin
              rx_sr <= {rx_sr[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_end) begin
              bit_cnt <= 4'h0;
              if (byte_idx == sebf_pkg::IDX_CTRL) begin
                if (ctrl_match) begin
                  sda_pin_oe <= 1'b1;
                  state <= sebf_pkg::ST_RX_ACK;
                  is_read <= rx_sr[0];
                  if (rx_sr[0]) begin
                    rd_req <= 1'b1;
                    rd_addr <= addr_ptr;
                    addr_ptr <= addr_ptr + 13'h0001;
                  end
                end else begin
                  state <= sebf_pkg::ST_IDLE;
                end
              end else begin
                sda_pin_oe <= 1'b1;
                state <= sebf_pkg::ST_RX_ACK;
                if (byte_idx == sebf_pkg::IDX_ADDR_HI) begin
                  addr_ptr[12:8] <= rx_sr[4:0];
                end else if (byte_idx == sebf_pkg::IDX_ADDR_LO) begin
                  addr_ptr[7:0] <= rx_sr;
                end else begin
                  push_pend <= 1'b1;
                  push_data <= rx_sr;
                  data_seen <= 1'b1;
                  addr_ptr <= page_inc(addr_ptr);
                end
              end
            end
          end
          sebf_pkg::ST_RX_ACK: begin
            // Ack held from one SCL fall to the next, covering the high phase
            if (scl_fall) begin
              byte_idx <= (byte_idx == sebf_pkg::IDX_DATA) ? byte_idx : byte_idx + 2'h1;
              if (is_read) begin
                state <= sebf_pkg::ST_TX;
                sda_pin_oe <= !tx_sr[7];
                tx_sr <= {tx_sr[6:0], 1'b1};
                bit_cnt <= 4'h1;
              end else begin
                state <= sebf_pkg::ST_RX;
                sda_pin_oe <= 1'b0;
              end
            end
          end
          sebf_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 4'(sebf_pkg::BITS_PER_BYTE)) begin
                sda_pin_oe <= 1'b0;
                bit_cnt <= 4'h0;
                got_ack <= 1'b0;
                state <= sebf_pkg::ST_TX_ACK;
              end else begin
                sda_pin_oe <= !tx_sr[7];
                tx_sr <= {tx_sr[6:0], 1'b1};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          sebf_pkg::ST_TX_ACK: begin
            if (scl_rise) begin
              if (!sda_f) begin
                got_ack <= 1'b1;
                rd_req <= 1'b1;
                rd_addr <= addr_ptr;
                addr_ptr <= addr_ptr + 13'h0001;
              end else begin
                state <= sebf_pkg::ST_IDLE;
              end
            end else if (scl_fall && got_ack) begin
              state <= sebf_pkg::ST_TX;
              sda_pin_oe <= !tx_sr[7];
              tx_sr <= {tx_sr[6:0], 1'b1};
              bit_cnt <= 4'h1;
            end
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Page buffer and write cycle
  logic fifo_out_valid, fifo_out_ready, fifo_flush, discard, launch;
  logic [sebf_pkg::DATA_W-1:0] fifo_out_data;
  logic [31:0] twc_cnt;
  logic [sebf_pkg::ADDR_W-1:0] page_addr;

  // Buffer full while receiving: oldest byte is dropped to make room
  assign discard = push_pend && !fifo_in_ready && !busy;
  assign fifo_out_ready = discard || (busy && (!wr_valid || wr_ready));
  assign launch = stop_det && data_seen && !busy;
  assign fifo_flush = (!busy && ((start_det && data_seen) || (launch && pin_s2[3])))
                      || (busy && (twc_cnt == 32'(TWC_CYCLES - 1)));

  sebf_fifo #(
    .WIDTH(sebf_pkg::DATA_W),
    .DEPTH(BUF_DEPTH)
  ) u_page_buf (
    .core_clk(core_clk),
    .rstn(rstn),
    .flush(fifo_flush),
    .in_valid(push_pend),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      twc_cnt <= 32'h00000000;
    end else if (launch && !pin_s2[3]) begin
      busy <= 1'b1;
      twc_cnt <= 32'h00000000;
    end else if (busy) begin
      twc_cnt <= twc_cnt + 32'h00000001;
      if (twc_cnt == 32'(TWC_CYCLES - 1)) begin
        busy <= 1'b0;
      end
    end
  end

  // Page address tracks the oldest kept byte, then walks the drain
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      page_addr <= 13'h0000;
    end else if (byte_end && byte_idx == sebf_pkg::IDX_ADDR_HI) begin
      page_addr[12:8] <= rx_sr[4:0];
    end else if (byte_end && byte_idx == sebf_pkg::IDX_ADDR_LO) begin
      page_addr[7:0] <= rx_sr;
    end else if (fifo_out_valid && fifo_out_ready) begin
      page_addr <= page_inc(page_addr);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_valid <= 1'b0;
      wr_word <= '0;
    end else if (busy && (!wr_valid || wr_ready)) begin
      wr_valid <= fifo_out_valid;
      wr_word <= '{addr: page_addr, data: fifo_out_data};
    end else if (wr_ready || !busy) begin
      wr_valid <= 1'b0;
    end
  end
endmodule

// *** dv/sebf_chk_asserts.sv ***
// Port-level concurrent checks for the bus front end
`timescale 1ns/100ps
module sebf_chk #(
  parameter int TWC_CYCLES = sebf_pkg::TWC_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  input wire logic sda_pin_out,
  input wire logic sda_pin_oe,
  input wire logic wp_pin,
  input wire logic chip_select_pin_bit0,
  input wire logic chip_select_pin_bit1,
  input wire logic chip_select_pin_bit2,
  input wire logic rd_req,
  input wire logic [sebf_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [sebf_pkg::DATA_W-1:0] rd_data,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire sebf_pkg::sebf_wr_s wr_word,
  input wire logic busy
);
  logic [31:0] busy_cnt;
  logic [sebf_pkg::ADDR_W-1:0] prev_addr;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      busy_cnt <= 32'h0;
    else
      busy_cnt <= busy ? busy_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      prev_addr <= '0;
    else if (wr_valid && wr_ready)
      prev_addr <= wr_word.addr;
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_busy_no_ack: assert property (busy |-> !sda_pin_oe)
    else $error("acknowledge driven during write cycle");
  a_wr_in_busy: assert property (wr_valid |-> busy || $past(busy))
    else $error("array write outside write cycle");
  a_busy_len: assert property ($fell(busy) |-> busy_cnt >= TWC_CYCLES - 1 &&
    busy_cnt <= TWC_CYCLES + 1) else $error("write cycle length wrong");
  a_rd_pulse: assert property (rd_req |=> !rd_req)
    else $error("read request longer than one cycle");
  a_rd_not_busy: assert property (rd_req |-> !busy)
    else $error("array read during write cycle");
  a_ack_stands: assert property ($rose(sda_pin_oe) |=> sda_pin_oe [*8])
    else $error("acknowledge dropped early");
  a_wr_page_wrap: assert property (wr_valid && wr_ready ##1 wr_valid |->
    wr_word.addr == {prev_addr[12:5], prev_addr[4:0] + 5'h01})
    else $error("page address not advancing");
  a_oe_scl_low: assert property ($changed(sda_pin_oe) |-> !scl_pin)
    else $error("data line changed with clock high");
  c_write_cycle: cover property ($rose(busy));
  c_read: cover property (rd_req);
  c_stall: cover property (wr_valid && !wr_ready ##1 wr_valid && wr_ready);
endmodule
bind sebf_front_end sebf_chk #(.TWC_CYCLES(TWC_CYCLES)) u_chk (
  .core_clk(core_clk), .rstn(rstn), .scl_pin(scl_pin), .sda_pin_in(sda_pin_in),
  .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe), .wp_pin(wp_pin),
  .chip_select_pin_bit0(chip_select_pin_bit0), .chip_select_pin_bit1(chip_select_pin_bit1),
  .chip_select_pin_bit2(chip_select_pin_bit2), .rd_req(rd_req), .rd_addr(rd_addr),
  .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
  .busy(busy)
);

// *** dv/sebf_master_model.sv ***
// Two-wire bus master model driving clock and data
`timescale 1ns/100ps
module sebf_master_model (
  input wire logic core_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Hold data 3 cycles past the fall so no false Start or Stop
  task automatic bitx(input logic b, output logic r);
    wt(3);
    sda_low = !b;
    wt(5);
    scl = 1'b1;
    wt(8);
    r = sda_wire;
    scl = 1'b0;
  endtask
  task automatic start();
    wt(3);
    sda_low = 1'b0;
    wt(5);
    scl = 1'b1;
    wt(8);
    sda_low = 1'b1;
    wt(8);
    scl = 1'b0;
  endtask
  task automatic stop();
    wt(3);
    sda_low = 1'b1;
    wt(5);
    scl = 1'b1;
    wt(8);
    sda_low = 1'b0;
    wt(8);
  endtask
  // Nine pulses; bit 0 is the acknowledge slot, master nack marks last read
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) bitx(tx[i], rx[i]);
  endtask
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the bus front end with array model
`timescale 1ns/100ps
module tb_top;
  localparam int TWC = 300;
  localparam logic [3:0] DEV = sebf_pkg::DEV_CODE_DFLT;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic wp_pin = 1'b0;
  logic [2:0] cs = 3'h0;
  logic wr_ready = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic scl, m_low, sda_oe, sda_out, rd_req, wr_valid, busy;
  logic [12:0] rd_addr;
  sebf_pkg::sebf_wr_s wr_word;
  // Open drain: the device value only counts while it pulls the line
  wire logic sda_wire = !(m_low || (sda_oe && !sda_out));
  logic [20:0] exp_q [$];
  logic [7:0] mem [8192];
  logic [7:0] ref_mem [8192];
  logic [31:0] rs = 32'hDAF3;
  int err_count = 0;
  int checks_done = 0;
  always #5 core_clk = ~core_clk;
  sebf_front_end #(.TWC_CYCLES(TWC)) dut (
    .core_clk(core_clk), .rstn(rstn), .scl_pin(scl), .sda_pin_in(sda_wire),
    .sda_pin_out(sda_out), .sda_pin_oe(sda_oe), .wp_pin(wp_pin), .chip_select_pin_bit0(cs[0]),
    .chip_select_pin_bit1(cs[1]), .chip_select_pin_bit2(cs[2]), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_word(wr_word), .busy(busy)
  );
  sebf_master_model m (.core_clk(core_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(m_low));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // Array side stalls at random
  always @(negedge core_clk) begin
    wr_ready <= 1'(rnd() >> 3);
    if (rd_req)
      rd_data <= mem[rd_addr];
  end
  // Every accepted array write must be the next one the page model predicts
  always @(posedge core_clk) begin
    if (wr_valid && wr_ready) begin
      mem[wr_word.addr] <= wr_word.data;
      chk(wr_word, exp_q.size() > 0 ? 32'(exp_q.pop_front()) : 32'hFFFFFFFF);
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wb(input logic [7:0] d, input logic ack);
    logic [8:0] r;
    m.xfer({d, 1'b1}, r);
    chk(!r[0], ack);
  endtask
  task automatic wait_busy(input logic v, input int lim);
    for (int i = 0; i < lim && busy !== v; i++) @(negedge core_clk);
    chk(busy, v);
  endtask
  task automatic rd_chk(input logic [12:0] a, input int n);
    logic [8:0] r;
    m.start();
    wb({DEV, cs, 1'b0}, 1'b1);
    wb({3'h5, a[12:8]}, 1'b1);
    wb(a[7:0], 1'b1);
    m.start();
    wb({DEV, cs, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.xfer({8'hFF, i == n - 1}, r);
      chk(r[8:1], ref_mem[13'(a + i)]);
    end
    m.stop();
  endtask
  initial begin
    int ptr;
    logic [7:0] d;
    logic r;
    logic [8:0] rb;
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'h00;
      ref_mem[i] = 8'h00;
    end
    cs = 3'(rnd());
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    repeat (10) @(negedge core_clk);
    // 34 bytes into a 32-byte page, junk in upper address bits
    ptr = 13'h0A5C;
    m.start();
    wb({DEV, cs, 1'b0}, 1'b1);
    wb(8'hEA, 1'b1);
    wb(8'h5C, 1'b1);
    for (int i = 0; i < 34; i++) begin
      d = 8'(rnd());
      ref_mem[{ptr[12:5], 5'(ptr + i)}] = d;
      if (i >= 34 - sebf_pkg::PAGE_BYTES) exp_q.push_back({ptr[12:5], 5'(ptr + i), d});
      wb(d, 1'b1);
    end
    m.stop();
    wait_busy(1'b1, 20);
    m.start();
    wb({DEV, cs, 1'b0}, 1'b0);
    m.stop();
    wait_busy(1'b0, TWC + 50);
    chk(exp_q.size(), 0);
    rd_chk(13'h0A3F, 3);
    // Current address read continues after the last byte read
    m.start();
    wb({DEV, cs, 1'b1}, 1'b1);
    m.xfer({8'hFF, 1'b1}, rb);
    chk(rb[8:1], ref_mem[13'h0A42]);
    m.stop();
    $display("test page_write done");
    wp_pin = 1'b1;
    m.start();
    wb({DEV, cs, 1'b0}, 1'b1);
    wb(8'h01, 1'b1);
    wb(8'h00, 1'b1);
    for (int i = 0; i < 3; i++) wb(8'(rnd()), 1'b1);
    m.stop();
    repeat (20) @(negedge core_clk);
    chk(busy, 1'b0);
    rd_chk(13'h0100, 2);
    wp_pin = 1'b0;
    $display("test write_protect done");
    for (int k = 0; k < 8; k++) begin
      m.start();
      wb({DEV, 3'(k), 1'b0}, 3'(k) == cs);
      m.stop();
    end
    m.start();
    wb({~DEV, cs, 1'b1}, 1'b0);
    m.stop();
    $display("test addressing done");
    m.start();
    for (int i = 0; i < 4; i++) m.bitx(1'b1, r);
    m.start();
    wb({DEV, cs, 1'b0}, 1'b1);
    m.stop();
    $display("test restart done");
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    end_of_test();
  end
endmodule
